// ==== msc_device.sv ====
// module end: select gating, reset and init timing, low power, presence, interrupt
`timescale 1ns/1ps
// How it works
// RULE_01: answer serial bus only while selected low
// RULE_02: deselected: never acknowledge nor drive data
// RULE_03: select input pulled up, floats deselected
// RULE_04: long reset low restores all settings default
// RULE_05: init interval starts at reset rising edge
// RULE_06: host ignores status until reset completes
// RULE_07: completion: interrupt with not-ready flag cleared
// RULE_08: power-up raises same completion interrupt
// RULE_09: low power input high enters reduced power
// RULE_10: presence tied low, host pulls up
// RULE_11: interrupt low reports fault or status
// RULE_12: host reads serial bus to find cause
// RULE_13: interrupt only pulled low or released
// RULE_14: host reads flag field after interrupt
// RULE_15: interrupt held while unmasked flags set
// RULE_16: host holds select through each transfer
module msc_device #(
	parameter int INIT_CYCLES = msc_pkg::INIT_CYC         // init interval in cycles
) (
	input  wire logic                      clk_i,          // module clock
	input  wire logic                      reset_n_i,      // async reset, active low
	msc_link_if.device                     link,           // sideband pins
	input  wire logic [msc_pkg::LANES-1:0] fault_event_i,  // per-lane fault pulses
	output logic      [7:0]                control_o,      // control byte setting
	output logic                           low_power_o,    // reduced power state
	output logic                           data_not_ready_o // init pending
);
	import msc_pkg::*;

	msc_dev_state_type r, n;
	logic scl_rise, scl_fall, start_c, stop_c, active;
	logic [7:0] rd;
	logic [LANES-1:0] fault_clr;
	logic init_clr;

	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[2] : f;
	endfunction

	// =========================================================
	// read data
	always_comb begin
		rd = 8'h00;
		if (r.ptr == ADDR_IDENT) begin
			rd = IDENT_VALUE;
		end else if (r.ptr == ADDR_STATUS) begin
			rd = {7'h00, r.dnr};
		end else if (r.ptr == ADDR_FLAG_INIT) begin
			rd = {7'h00, r.flag_init};
		end else if (r.ptr == ADDR_FLAG_FAULT) begin
			rd = {4'h0, r.flag_fault};
		end else if (r.ptr == ADDR_CONTROL) begin
			rd = r.control;
		end else if (r.ptr == ADDR_MASK) begin
			rd = r.mask;
		end else if (r.ptr == ADDR_PAGE) begin
			rd = r.page;
		end
	end

	// =========================================================
	// next state
	always_comb begin
		n = r;
		fault_clr = '0;
		init_clr = 1'b0;
		n.sel_s = {r.sel_s[1:0], link.module_select_n};
		n.rst_s = {r.rst_s[1:0], link.module_reset_n};
		n.lp_s  = {r.lp_s[1:0], link.low_power_request};
		n.scl_s = {r.scl_s[1:0], link.scl};
		n.sda_s = {r.sda_s[1:0], link.sda};
		n.sel_f = filt(r.sel_s, r.sel_f);
		n.rst_f = filt(r.rst_s, r.rst_f);
		n.lp_f  = filt(r.lp_s, r.lp_f);
		n.scl_f = filt(r.scl_s, r.scl_f);
		n.sda_f = filt(r.sda_s, r.sda_f);
		scl_rise = n.scl_f && !r.scl_f;
		scl_fall = !n.scl_f && r.scl_f;
		start_c = r.scl_f && n.scl_f && !n.sda_f && r.sda_f;
		stop_c = r.scl_f && n.scl_f && n.sda_f && !r.sda_f;
		active = !r.sel_f && !r.in_reset;                 // [RULE_01]
		n.low_power = r.lp_f;                             // [RULE_09]
		n.present_oe = 1'b1;                              // [RULE_10]

		// reset pulse measurement and init timing
		if (!r.rst_f) begin
			if (r.low_cnt != CNT_W'(RESET_MIN_CYC)) begin
				n.low_cnt = r.low_cnt + 1'b1;
			end else begin
				n.in_reset = 1'b1;                        // [RULE_04]
			end
		end else begin
			n.low_cnt = '0;
			if (r.in_reset) begin
				n.in_reset = 1'b0;
				n.init_run = 1'b1;                        // [RULE_05]
				n.init_cnt = '0;
			end
		end
		if (r.init_run) begin
			n.init_cnt = r.init_cnt + 1'b1;
			if (r.init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
				n.init_run = 1'b0;
			end
		end

		// serial slave
		case (r.st)
			D_IDLE: n.sda_oe = 1'b0;
			D_ADDR, D_RX: begin
				if (scl_rise) begin
					n.shreg = {r.shreg[6:0], r.sda_f};
					n.bitcnt = r.bitcnt + 1'b1;
				end else if (scl_fall && r.bitcnt == 4'h8) begin
					n.sda_oe = 1'b1;
					n.st = D_ACK;
					if (r.st == D_ADDR) begin
						n.rw = r.shreg[0];
						if (r.shreg[7:1] != DEV_ADDR) begin
							n.sda_oe = 1'b0;
							n.st = D_IDLE;
						end
					end else if (r.first) begin
						n.ptr = r.shreg;
						n.first = 1'b0;
					end else begin
						n.ptr = r.ptr + 1'b1;
						if (r.ptr == ADDR_CONTROL) begin
							n.control = r.shreg;
						end else if (r.ptr == ADDR_MASK) begin
							n.mask = r.shreg;
						end else if (r.ptr == ADDR_PAGE) begin
							n.page = r.shreg;
						end
					end
				end
			end
			D_ACK: begin
				if (scl_fall) begin
					n.bitcnt = 4'h0;
					n.sda_oe = 1'b0;
					n.st = D_RX;
					if (r.rw) begin
						n.shreg = rd;
						n.sda_oe = ~rd[7];
						n.ptr = r.ptr + 1'b1;
						n.st = D_TX;
						init_clr = (r.ptr == ADDR_FLAG_INIT);
						fault_clr = {LANES{r.ptr == ADDR_FLAG_FAULT}};
					end
				end
			end
			D_TX: begin
				if (scl_fall) begin
					if (r.bitcnt == 4'h7) begin
						n.sda_oe = 1'b0;
						n.st = D_TXACK;
					end else begin
						n.shreg = {r.shreg[6:0], 1'b0};
						n.sda_oe = ~r.shreg[6];
						n.bitcnt = r.bitcnt + 1'b1;
					end
				end
			end
			D_TXACK: begin
				if (scl_rise) begin
					n.st = r.sda_f ? D_IDLE : D_ACK;
				end
			end
			default: n.st = D_IDLE;
		endcase
		if (start_c) begin
			n.st = D_ADDR;
			n.bitcnt = 4'h0;
			n.first = 1'b1;
			n.sda_oe = 1'b0;
		end else if (stop_c) begin
			n.st = D_IDLE;
			n.sda_oe = 1'b0;
		end
		if (!active) begin
			n.st = D_IDLE;                                // [RULE_02]
			n.sda_oe = 1'b0;                              // [RULE_02]
		end

		// latched flags, a new event beats a clear-on-read in the same cycle
		n.flag_fault = (r.flag_fault & ~fault_clr) | fault_event_i;
		n.flag_init = r.flag_init && !init_clr;
		n.dnr = r.dnr;
		if (r.init_run && r.init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
			n.dnr = 1'b0;                                 // [RULE_07]
			n.flag_init = 1'b1;                           // [RULE_07] [RULE_08]
		end
		if (r.in_reset) begin
			n.control = CONTROL_RST;                      // [RULE_04]
			n.mask = MASK_RST;
			n.page = PAGE_RST;
			n.dnr = 1'b1;
			n.flag_init = 1'b0;
			n.flag_fault = '0;
		end
		// open-drain low while any unmasked flag is latched [RULE_11] [RULE_13] [RULE_15]
		n.int_oe = r.flag_init || (|(r.flag_fault & ~r.mask[LANES-1:0]));
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
			r.sel_s <= SYNC_HI_RST;                       // [RULE_03]
			r.rst_s <= SYNC_HI_RST;
			r.scl_s <= SYNC_HI_RST;
			r.sda_s <= SYNC_HI_RST;
			r.sel_f <= 1'b1;
			r.rst_f <= 1'b1;
			r.scl_f <= 1'b1;
			r.sda_f <= 1'b1;
			r.control <= CONTROL_RST;
			r.mask <= MASK_RST;
			r.page <= PAGE_RST;
			r.init_run <= 1'b1;                           // [RULE_08]
			r.dnr <= 1'b1;
			r.present_oe <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// =========================================================
	// outputs
	assign link.dev_sda_o     = 1'b0;
	assign link.dev_sda_oe    = r.sda_oe;
	assign link.dev_int_o     = 1'b0;
	assign link.dev_int_oe    = r.int_oe;
	assign link.dev_present_o = 1'b0;
	assign link.dev_present_oe = r.present_oe;
	assign control_o          = r.control;
	assign low_power_o        = r.low_power;
	assign data_not_ready_o   = r.dnr;
endmodule

// ==== msc_host.sv ====
// host board controller end: select, reset, low power and 2-wire master
`timescale 1ns/1ps
module msc_host (
	input  wire logic                  clk_i,             // system clock
	input  wire logic                  reset_n_i,         // async reset, active low
	msc_link_if.host                   link,              // sideband pins
	input  wire logic                  cmd_valid_i,       // access request
	input  wire logic                  cmd_write_i,       // 1 write, 0 read
	input  wire logic [7:0]            cmd_addr_i,        // byte address
	input  wire logic [7:0]            cmd_wdata_i,       // write data
	output logic                       cmd_ready_o,       // request taken when high
	output logic                       rsp_valid_o,       // one-cycle answer
	output logic                       rsp_auto_o,        // answer from interrupt service
	output logic                       rsp_nack_o,        // module did not acknowledge
	output logic [7:0]                 rsp_addr_o,        // address of answer
	output logic [7:0]                 rsp_data_o,        // read data, write data echoed on writes
	input  wire logic                  reset_req_i,       // pulse module reset
	input  wire logic                  low_power_i,       // request low power
	output logic                       module_present_o,  // module inserted
	output logic                       interrupt_o,       // interrupt seen
	output logic                       status_trusted_o   // status bits valid
);
	import msc_pkg::*;

	msc_host_state_type r, n;
	logic step_end;

	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[2] : f;
	endfunction

	function automatic logic [8:0] tx_for(input logic [1:0] bi, input logic wr,
		input logic [7:0] a, input logic [7:0] d);
		if (bi == 2'h0) begin
			tx_for = {DEV_ADDR, 1'b0, 1'b1};
		end else if (bi == 2'h1) begin
			tx_for = {a, 1'b1};
		end else if (bi == 2'h2) begin
			tx_for = wr ? {d, 1'b1} : {DEV_ADDR, 1'b1, 1'b1};
		end else begin
			tx_for = 9'h1ff;
		end
	endfunction

	// =========================================================
	// next state
	always_comb begin
		n = r;
		n.int_s = {r.int_s[1:0], link.interrupt_out_n};
		n.prs_s = {r.prs_s[1:0], link.module_present_n};
		n.sda_s = {r.sda_s[1:0], link.sda};
		n.int_f = filt(r.int_s, r.int_f);
		n.prs_f = filt(r.prs_s, r.prs_f);
		n.sda_f = filt(r.sda_s, r.sda_f);
		n.present = ~r.prs_f;                             // [RULE_10]
		n.intr = ~r.int_f;
		n.lp = low_power_i;                               // [RULE_09]
		n.rsp_valid = 1'b0;
		step_end = (r.qcnt == Q_W'(SCL_QUARTER_CYC - 1)) && (r.q == 2'h3);
		if (r.st != H_IDLE && r.st != H_RESET) begin
			n.qcnt = (r.qcnt == Q_W'(SCL_QUARTER_CYC - 1)) ? '0 : r.qcnt + 1'b1;
			if (r.qcnt == Q_W'(SCL_QUARTER_CYC - 1)) begin
				n.q = r.q + 1'b1;
			end
		end
		case (r.st)
			H_IDLE: begin
				n.qcnt = '0;
				n.q = 2'h0;
				n.bi = 2'h0;
				n.nack = 1'b0;
				if (reset_req_i) begin
					n.st = H_RESET;
					n.rst_oe = 1'b1;
					n.rcnt = '0;
					n.trusted = 1'b0;                     // [RULE_06]
				end else if (cmd_valid_i && r.cmd_ready) begin
					n.st = H_SETUP;
					n.write = cmd_write_i;
					n.addr = cmd_addr_i;
					n.wdata = cmd_wdata_i;
					n.auto = 1'b0;
				end else if (!r.int_f) begin
					n.st = H_SETUP;                        // [RULE_12] [RULE_14]
					n.write = 1'b0;
					n.addr = ADDR_STATUS + {6'h00, r.auto_idx};
					n.auto = 1'b1;
				end
			end
			H_SETUP: begin
				n.sel_oe = 1'b1;                          // [RULE_16]
				if (step_end) begin
					n.st = H_START;
				end
			end
			H_START: begin
				n.sda_oe = (r.q >= 2'h2);
				n.scl_oe = (r.q == 2'h3) || (r.q == 2'h0 && r.scl_oe);
				if (step_end) begin
					n.st = H_BIT;
					n.bitn = 4'h0;
					n.tx = tx_for(r.bi, r.write, r.addr, r.wdata);
				end
			end
			H_BIT: begin
				n.scl_oe = (r.q == 2'h0) || (r.q == 2'h3);
				n.sda_oe = ~r.tx[8];
				if (r.q == 2'h2 && r.qcnt == '0) begin
					n.smp = r.sda_f;
				end
				if (step_end) begin
					n.tx = {r.tx[7:0], 1'b1};
					n.bitn = r.bitn + 1'b1;
					if (r.bitn != 4'h8) begin
						n.rx = {r.rx[6:0], r.smp};
					end else if (r.bi != 2'h3 && r.smp) begin
						n.nack = 1'b1;
						n.st = H_STOP;
					end else if ((r.write && r.bi == 2'h2) || r.bi == 2'h3) begin
						n.st = H_STOP;
					end else if (!r.write && r.bi == 2'h1) begin
						n.bi = 2'h2;
						n.st = H_START;
					end else begin
						n.bi = r.bi + 1'b1;
						n.bitn = 4'h0;
						n.tx = tx_for(r.bi + 1'b1, r.write, r.addr, r.wdata);
					end
				end
			end
			H_STOP: begin
				n.scl_oe = (r.q == 2'h0);
				n.sda_oe = (r.q <= 2'h1);
				if (step_end) begin
					n.st = H_HOLD;
				end
			end
			H_HOLD: begin
				if (step_end) begin
					n.st = H_IDLE;
					n.sel_oe = 1'b0;
					n.rsp_valid = 1'b1;
					n.rsp_auto = r.auto;
					n.rsp_nack = r.nack;
					n.rsp_addr = r.addr;
					n.rsp_data = r.write ? r.wdata : r.rx;
					if (!r.write && !r.nack && r.addr == ADDR_STATUS && !r.rx[DNR_BIT]) begin
						n.trusted = 1'b1;                 // [RULE_06]
					end
					if (r.auto) begin
						n.auto_idx = (r.auto_idx == AUTO_IDX_MAX) ? 2'h0 : r.auto_idx + 1'b1;
					end
				end
			end
			H_RESET: begin
				n.rcnt = r.rcnt + 1'b1;
				n.auto_idx = 2'h0;
				if (r.rcnt == CNT_W'(RESET_HOLD_CYC - 1)) begin
					n.rst_oe = 1'b0;
					n.st = H_IDLE;
				end
			end
			default: n.st = H_IDLE;
		endcase
		n.cmd_ready = (n.st == H_IDLE) && !reset_req_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
			r.int_s <= SYNC_HI_RST;
			r.prs_s <= SYNC_HI_RST;
			r.sda_s <= SYNC_HI_RST;
			r.int_f <= 1'b1;
			r.prs_f <= 1'b1;
			r.sda_f <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// =========================================================
	// outputs
	assign link.host_select_oe    = r.sel_oe;
	assign link.host_reset_oe     = r.rst_oe;
	assign link.low_power_request = r.lp;
	assign link.host_scl_o        = 1'b0;
	assign link.host_scl_oe       = r.scl_oe;
	assign link.host_sda_o        = 1'b0;
	assign link.host_sda_oe       = r.sda_oe;
	assign cmd_ready_o            = r.cmd_ready;
	assign rsp_valid_o            = r.rsp_valid;
	assign rsp_auto_o             = r.rsp_auto;
	assign rsp_nack_o             = r.rsp_nack;
	assign rsp_addr_o             = r.rsp_addr;
	assign rsp_data_o             = r.rsp_data;
	assign module_present_o       = r.present;
	assign interrupt_o            = r.intr;
	assign status_trusted_o       = r.trusted;
endmodule

// ==== msc_link_if.sv ====
// sideband pins between host board controller and module, with pull-up resolution
`timescale 1ns/1ps
interface msc_link_if;
	logic host_select_oe;
	logic host_reset_oe;
	logic low_power_request;
	logic host_scl_o, host_scl_oe;
	logic host_sda_o, host_sda_oe;
	logic dev_sda_o, dev_sda_oe;
	logic dev_int_o, dev_int_oe;
	logic dev_present_o, dev_present_oe;
	logic module_select_n;
	logic module_reset_n;
	logic scl;
	logic sda;
	logic interrupt_out_n;
	logic module_present_n;

	// undriven select and reset float high through the module pull-ups [RULE_03]
	assign module_select_n  = host_select_oe ? 1'b0 : 1'b1;
	assign module_reset_n   = host_reset_oe ? 1'b0 : 1'b1;
	assign scl              = host_scl_oe ? host_scl_o : 1'b1;
	assign sda              = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	// open-drain lines, high level from the host pull-up [RULE_13] [RULE_10]
	assign interrupt_out_n  = dev_int_oe ? dev_int_o : 1'b1;
	assign module_present_n = dev_present_oe ? dev_present_o : 1'b1;

	modport device (
		input  module_select_n, module_reset_n, low_power_request, scl, sda,
		output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe, dev_present_o, dev_present_oe
	);
	modport host (
		input  sda, interrupt_out_n, module_present_n,
		output host_select_oe, host_reset_oe, low_power_request,
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
	);
endinterface

// ==== msc_link_properties.sv ====
// concurrent properties on the sideband link between host end and module end
`timescale 1ns/1ps
module msc_link_properties
	import msc_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC         // init interval in cycles
) (
	input  wire logic clk_i,                     // system clock
	input  wire logic reset_n_i,                 // async reset, active low
	input  wire logic host_reset_oe,             // host pulls module reset low
	input  wire logic dev_sda_oe,                // module drives data line
	input  wire logic dev_int_o,                 // module interrupt drive level
	input  wire logic dev_int_oe,                // module pulls interrupt low
	input  wire logic module_select_n,           // resolved select level
	input  wire logic module_reset_n,            // resolved module reset level
	input  wire logic scl,                       // resolved serial clock
	input  wire logic sda,                       // resolved serial data
	input  wire logic interrupt_out_n,           // resolved interrupt level
	input  wire logic module_present_n           // resolved presence level
);
	// =========================================================
	// reset pulse length and time since the last full reset
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] since;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_cnt <= '0;
			since   <= '0;
		end else begin
			low_cnt <= module_reset_n ? '0 : low_cnt + 1'b1;
			if (!module_reset_n && low_cnt >= RESET_MIN_CYC + 8)
				since <= '0;
			else if (since < INIT_CYCLES + 20)
				since <= since + 1'b1;
		end
	end

	// =========================================================
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	desel_quiet_a: assert property (module_select_n [*8] |-> !dev_sda_oe)
		else $error("data line driven while deselected");
	sda_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("module data changed while clock high");
	select_frame_a: assert property ($changed(module_select_n) |-> scl && sda)
		else $error("select changed inside a transfer");
	int_opendrain_a: assert property (dev_int_oe |-> !dev_int_o)
		else $error("interrupt driven high");
	present_low_a: assert property (!module_present_n)
		else $error("presence line not low");
	reset_clear_a: assert property (low_cnt >= RESET_MIN_CYC + 8 |-> !dev_int_oe)
		else $error("interrupt held through full reset");
	reset_width_a: assert property ($fell(host_reset_oe) |-> $past(host_reset_oe, 300))
		else $error("module reset pulse too short");
	init_quiet_a: assert property (since < INIT_CYCLES |-> interrupt_out_n)
		else $error("completion interrupt before init interval");
	init_done_a: assert property (since == INIT_CYCLES + 12 |-> !interrupt_out_n)
		else $error("no completion interrupt after init interval");

	cover property (low_cnt == RESET_MIN_CYC + 8);
	cover property ($rose(dev_sda_oe) && !module_select_n);
	cover property ($fell(interrupt_out_n));
endmodule

// ==== msc_pkg.sv ====
// constants and state types shared by both ends of the module sideband link
package msc_pkg;
	// =========================================================
	// clock and timing
	localparam int CLK_MHZ         = 250;
	localparam int LANES           = 4;
	localparam int CNT_W           = 20;
	localparam int T_RESET_MIN_NS  = 2000;
	localparam int RESET_MIN_CYC   = (T_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int T_INIT_NS       = 2000000;
	localparam int INIT_CYC        = (T_INIT_NS * CLK_MHZ) / 1000;
	localparam int T_RESET_HOLD_NS = 4000;
	localparam int RESET_HOLD_CYC  = (T_RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SCL_QUARTER_CYC = 16;
	localparam int Q_W             = 5;

	// =========================================================
	// serial address and memory offsets
	localparam logic [6:0] DEV_ADDR        = 7'h50;
	localparam logic [7:0] ADDR_IDENT      = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h02;
	localparam logic [7:0] ADDR_FLAG_INIT  = 8'h03;
	localparam logic [7:0] ADDR_FLAG_FAULT = 8'h04;
	localparam logic [7:0] ADDR_CONTROL    = 8'h56;
	localparam logic [7:0] ADDR_MASK       = 8'h64;
	localparam logic [7:0] ADDR_PAGE       = 8'h7f;
	localparam int         DNR_BIT         = 0;

	// =========================================================
	// values after reset, identity value and auto-read index limit
	localparam logic [7:0] IDENT_VALUE  = 8'h00; // arbitrary value
	localparam logic [7:0] CONTROL_RST  = 8'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic [7:0] PAGE_RST     = 8'h00;
	localparam logic [2:0] SYNC_HI_RST  = 3'h7;
	localparam logic [1:0] AUTO_IDX_MAX = 2'h2;

	// =========================================================
	// state types
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_ACK, D_TX, D_TXACK} msc_dev_st_type;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_START, H_BIT, H_STOP, H_HOLD, H_RESET}
		msc_host_st_type;

	typedef struct packed {
		logic [2:0]       sel_s, rst_s, lp_s, scl_s, sda_s;
		logic             sel_f, rst_f, lp_f, scl_f, sda_f;
		logic [CNT_W-1:0] low_cnt, init_cnt;
		logic             in_reset, init_run, dnr, flag_init;
		logic [LANES-1:0] flag_fault;
		logic [7:0]       control, mask, page, ptr, shreg;
		logic [3:0]       bitcnt;
		logic             rw, first;
		msc_dev_st_type   st;
		logic             sda_oe, int_oe, present_oe, low_power;
	} msc_dev_state_type;

	typedef struct packed {
		logic [2:0]       int_s, prs_s, sda_s;
		logic             int_f, prs_f, sda_f;
		msc_host_st_type  st;
		logic [Q_W-1:0]   qcnt;
		logic [1:0]       q, bi, auto_idx;
		logic [3:0]       bitn;
		logic [8:0]       tx;
		logic [7:0]       rx, addr, wdata;
		logic [CNT_W-1:0] rcnt;
		logic             write, auto, smp, nack;
		logic             sel_oe, rst_oe, scl_oe, sda_oe, lp;
		logic             cmd_ready, rsp_valid, rsp_auto, rsp_nack, trusted, present, intr;
		logic [7:0]       rsp_addr, rsp_data;
	} msc_host_state_type;
endpackage

// ==== tb_module_sideband_control.sv ====
// self-checking bench joining host end and module end over the sideband link
`timescale 1ns/1ps
module tb_module_sideband_control;
	import msc_pkg::*;
	localparam int INIT_SIM = 200;
	logic             clk_i, reset_n_i, cmd_valid_i, cmd_write_i, reset_req_i, low_power_i;
	logic [7:0]       cmd_addr_i, cmd_wdata_i, rsp_addr_o, rsp_data_o, control_o, rd;
	logic             cmd_ready_o, rsp_valid_o, rsp_auto_o, rsp_nack_o, low_power_o;
	logic             module_present_o, interrupt_o, status_trusted_o, data_not_ready_o;
	logic [LANES-1:0] fault_event_i;
	int               error_cnt = 0;
	int               check_count = 0;

	msc_link_if link ();
	msc_host msc_host_i (.clk_i, .reset_n_i, .link, .cmd_valid_i, .cmd_write_i, .cmd_addr_i,
		.cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_auto_o, .rsp_nack_o, .rsp_addr_o,
		.rsp_data_o, .reset_req_i, .low_power_i, .module_present_o, .interrupt_o,
		.status_trusted_o);
	msc_device #(.INIT_CYCLES(INIT_SIM)) msc_device_i (.clk_i, .reset_n_i, .link,
		.fault_event_i, .control_o, .low_power_o, .data_not_ready_o);
	msc_link_properties #(.INIT_CYCLES(INIT_SIM)) msc_link_properties_i (.clk_i, .reset_n_i,
		.host_reset_oe(link.host_reset_oe), .dev_sda_oe(link.dev_sda_oe),
		.dev_int_o(link.dev_int_o), .dev_int_oe(link.dev_int_oe),
		.module_select_n(link.module_select_n), .module_reset_n(link.module_reset_n),
		.scl(link.scl), .sda(link.sda), .interrupt_out_n(link.interrupt_out_n),
		.module_present_n(link.module_present_n));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// =========================================================
	// tasks
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic seen(input int k);
		case (k)
			0: return interrupt_o === 1'b1;
			1: return interrupt_o === 1'b0;
			default: return link.module_reset_n === 1'b0;
		endcase
	endfunction

	// bounded wait for an event; running out ends the run
	task automatic await(input int k, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge clk_i);
			if (seen(k)) break;
		end
		if (n == lim) begin
			check(8'h00, 8'h01, "timeout");
			finish_test();
		end
	endtask

	// one single-byte access through the host request group
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		cmd_valid_i <= 1'b1;
		cmd_write_i <= wr;
		cmd_addr_i  <= a;
		cmd_wdata_i <= d;
		for (n = 0; n < 6000; n++) begin
			@(posedge clk_i);
			if (cmd_ready_o === 1'b1) break;
		end
		cmd_valid_i <= 1'b0;
		if (n == 6000) begin
			check(8'h00, 8'h01, "timeout");
			finish_test();
		end
		for (n = 0; n < 6000; n++) begin
			@(posedge clk_i);
			if (rsp_valid_o === 1'b1 && rsp_auto_o === 1'b0) break;
		end
		if (n == 6000) begin
			check(8'h00, 8'h01, "timeout");
			finish_test();
		end
		rd = rsp_data_o;
		check({7'h0, rsp_nack_o}, 8'h00, "acknowledge");
		check(rsp_addr_o, a, "answer address");
	endtask

	// =========================================================
	// main sequence
	initial begin
		reset_n_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_write_i = 1'b0;
		cmd_addr_i = 8'h00;
		cmd_wdata_i = 8'h00;
		reset_req_i = 1'b0;
		low_power_i = 1'b0;
		fault_event_i = '0;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		await(0, INIT_SIM + 200);
		check({7'h0, data_not_ready_o}, 8'h00, "not ready");
		check({7'h0, module_present_o}, 8'h01, "present");
		access(1'b0, ADDR_FLAG_INIT, 8'h00);
		check(rd, 8'h01, "init flag");
		await(1, 300);
		access(1'b0, ADDR_STATUS, 8'h00);
		check(rd, 8'h00, "status");
		@(posedge clk_i);
		check({7'h0, status_trusted_o}, 8'h01, "trusted");
		access(1'b1, ADDR_CONTROL, 8'ha5);
		access(1'b0, ADDR_CONTROL, 8'h00);
		check(rd, 8'ha5, "control read");
		check(control_o, 8'ha5, "control out");
		access(1'b1, ADDR_MASK, 8'h0f);
		fault_event_i <= 4'h4;
		@(posedge clk_i);
		fault_event_i <= 4'h0;
		repeat (50) @(posedge clk_i);
		check({7'h0, interrupt_o}, 8'h00, "masked fault");
		access(1'b1, ADDR_MASK, 8'h00);
		check({7'h0, link.interrupt_out_n}, 8'h00, "fault interrupt");
		access(1'b0, ADDR_FLAG_FAULT, 8'h00);
		check(rd, 8'h04, "fault flags");
		await(1, 300);
		low_power_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		check({7'h0, low_power_o}, 8'h01, "low power on");
		low_power_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check({7'h0, low_power_o}, 8'h00, "low power off");
		reset_req_i <= 1'b1;
		await(2, 100);
		reset_req_i <= 1'b0;
		check({7'h0, status_trusted_o}, 8'h00, "untrusted");
		await(0, RESET_HOLD_CYC + INIT_SIM + 500);
		check({7'h0, data_not_ready_o}, 8'h00, "not ready");
		access(1'b0, ADDR_CONTROL, 8'h00);
		check(rd, CONTROL_RST, "control default");
		check(control_o, CONTROL_RST, "control out default");
		finish_test();
	end
endmodule
